// ---- hdl/partition_pkg.sv ----
// package: constants, types and register map of the partition manager
`default_nettype none
package partition_pkg;
  localparam int NUM_PORTS = 16;
  localparam int NUM_PARTS = 16;
  localparam int PART_W    = 4;
  localparam int PORT_W    = 4;
  // register byte offsets, one aligned word each
  localparam logic [11:0] PORT_CTL_BASE  = 12'h000; // port_control_register x at base+4x
  localparam logic [11:0] PART_CTL_BASE  = 12'h040; // partition_control_register x
  localparam logic [11:0] PART_STS_BASE  = 12'h080; // partition_status_register x
  localparam logic [11:0] SBR_CTL_BASE   = 12'h0c0; // bridge_control_register x
  localparam logic [11:0] LINK_STS_ADDR  = 12'h100; // link up / data link down inputs
  // port_control_register fields
  localparam int MODE_LSB = 0;
  localparam int PSEL_LSB = 4;
  // partition_control_register fields
  localparam int DLDHR_BIT = 0;
  // partition_status_register fields
  localparam int USP_BIT  = 0;
  localparam int USN_LSB  = 4;
  // bridge_control_register fields
  localparam int SBR_BIT  = 6;
  // reset values
  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [3:0]  PSEL_RST = 4'h0;

  typedef enum logic [1:0] {
    MODE_DISABLED   = 2'h0,
    MODE_DOWNSTREAM = 2'h1,
    MODE_UPSTREAM   = 2'h2,
    MODE_UNATTACHED = 2'h3
  } port_mode_t;

  typedef struct packed {
    port_mode_t        mode;
    logic [PART_W-1:0] port_partition_select;
  } port_cfg_t;

  // received packet classification request
  typedef struct packed {
    logic              valid;
    logic [PORT_W-1:0] ingress_port;
    logic              is_completion;
    logic              is_cfg_to_upstream;
    logic              targets_downstream;
    logic              switch_generated;
  } pkt_req_t;

  typedef struct packed {
    logic valid;
    logic forward;
    logic unsupported;
    logic drop;
  } pkt_res_t;

  typedef struct packed {
    port_cfg_t [NUM_PORTS-1:0] port_cfg;
    logic [NUM_PARTS-1:0]      disable_linkdown_hot_reset;
    logic [NUM_PORTS-1:0]      secondary_bus_reset_bit;
    logic [NUM_PARTS-1:0]      upstream_port_present;
    logic [NUM_PARTS-1:0][PORT_W-1:0] upstream_port_number;
    logic [NUM_PARTS-1:0]      has_downstream;
    logic [31:0]               prdata;
    pkt_res_t                  pkt_res;
    logic [NUM_PARTS-1:0]      hot_reset_run;
  } state_t;
endpackage : partition_pkg
`default_nettype wire

// ---- hdl/switch_partition_manager.sv ----
// switch partition manager: port attachment, partition status, packet policy
//
// What this block does
// - sixteen independent partitions, IDs zero to fifteen
// - four port modes: disabled, down, up, unattached
// - port joins selected partition only when operational
// - disabled or unattached ports join no partition
// - mode change touches only related partitions
// - upstream-present set when upstream port attached
// - upstream port number reported while present
// - empty partition has no functional effect
// - up-only partition: requests unsupported except upstream config
// - up-only partition: completions unsupported
// - up-only partition: upstream power states free
// - no-upstream partition forwards peer-to-peer packets
// - no-upstream partition: non-downstream packets unsupported
// - no-upstream partition drops switch-generated rootward packets
// - no-upstream partition: downstream power states free
// - secondary reset: linked-up downstream sends hot-reset TS1
// - secondary reset discards that port's queued packets
// - secondary reset leaves other partitions untouched
// - link-down hot reset disable bit suppresses reset steps
`default_nettype none
module switch_partition_manager
  import partition_pkg::*;
(
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // port link status pins
  input  wire logic [NUM_PORTS-1:0]         link_up_pin,
  input  wire logic [NUM_PORTS-1:0]         dl_down_pin,
  // packet classification
  input  wire partition_pkg::pkt_req_t      pkt_req,
  output partition_pkg::pkt_res_t           pkt_res,
  // port actions
  output logic      [NUM_PORTS-1:0]         send_hot_reset_ts1,
  output logic      [NUM_PORTS-1:0]         flush_ingress_queue,
  output logic      [NUM_PORTS-1:0]         aspm_independent,
  output logic      [NUM_PARTS-1:0]         partition_hot_reset
);
  import partition_pkg::*;

  // register map, one aligned 32-bit word per register:
  //   port_control_register x at 0x000 + 4x
  //     mode in bits 1:0, partition select in bits 7:4
  //     mode codes: 0 disabled, 1 downstream, 2 upstream, 3 unattached
  //   partition_control_register x at 0x040 + 4x
  //     disable_linkdown_hot_reset in bit 0
  //   partition_status_register x at 0x080 + 4x, read only
  //     upstream_port_present in bit 0
  //     upstream_port_number in bits 7:4
  //   bridge_control_register x at 0x0c0 + 4x
  //     secondary_bus_reset_bit in bit 6
  //   link status word at 0x100, read only
  //     synced link up in bits 15:0
  //     synced data link down in bits 31:16
  //   any other word reads zero and ignores writes, no error
  //
  // bus timing:
  //   zero wait states, pready tied high
  //   read data is registered at the setup edge, so the word
  //   already stands in the access cycle when the master takes it
  //   writes commit at the access edge
  //   back to back transfers need no idle cycle
  //
  // partition status:
  //   recomputed from the port configuration every cycle
  //   follows a port control write by one clock
  //   number field is meaningless while present is clear
  //   two upstream ports in one partition is an invalid form;
  //   the lower port number is reported then
  //   a partition with no ports shows present clear and
  //   has no effect on any packet or port action
  //
  // packet policy, one result per request, one clock later:
  //   ingress port unattached: drop
  //   downstream ingress port in secondary bus reset: drop
  //   upstream only: completions and requests unsupported,
  //     except config aimed at the upstream port itself
  //   switch-generated packets in an upstream-only partition
  //     still have a root above them and are forwarded
  //   no upstream: peer traffic forwarded, rest unsupported,
  //     switch-generated rootward packets dropped silently
  //   upstream with downstream ports: normal forwarding
  //   the policy reads registered status, so a packet in the
  //   clock right after a port write sees the old partition form
  //
  // port actions:
  //   hot-reset training sets only on linked-up downstream ports
  //   whose own secondary bus reset bit is set
  //   the queue flush follows the same bit, link up or not
  //   link power states are free on the side that has no partner
  //
  // hazards and limits:
  //   link pins are asynchronous, so only the second
  //   synchroniser stage feeds any logic
  //   the secondary bus reset bit is a plain software bit;
  //   software clears it to end the reset
  //   a port's configuration write touches only that port's
  //   entry, so unrelated partitions never see a mode change
  //   the hot reset disable bit only masks the link-down trigger;
  //   other hot reset causes are handled outside this block
  //   partition and port state machines live elsewhere

  state_t state;
  state_t next_state;
  logic [NUM_PORTS-1:0] link_up_meta;
  logic [NUM_PORTS-1:0] link_up_sync;
  logic [NUM_PORTS-1:0] dl_down_meta;
  logic [NUM_PORTS-1:0] dl_down_sync;
  logic [NUM_PORTS-1:0][PART_W-1:0] attach_part;
  logic [NUM_PORTS-1:0] attached;
  logic [NUM_PORTS-1:0] is_up;
  logic [NUM_PORTS-1:0] is_down;

  // two-flop synchronisers for the link status pins
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_up_meta <= '0;
      link_up_sync <= '0;
      dl_down_meta <= '0;
      dl_down_sync <= '0;
    end
    else
    begin
      link_up_meta <= link_up_pin;
      link_up_sync <= link_up_meta;
      dl_down_meta <= dl_down_pin;
      dl_down_sync <= dl_down_meta;
    end
  end

  // per-port attachment decode
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    assign is_up[p]       = state.port_cfg[p].mode == MODE_UPSTREAM;
    assign is_down[p]     = state.port_cfg[p].mode == MODE_DOWNSTREAM;
    assign attached[p]    = is_up[p] | is_down[p];
    assign attach_part[p] = state.port_cfg[p].port_partition_select;
  end

  // next state: bus access, status derivation, packet policy
  always_comb
  begin
    logic              acc;
    logic [5:0]        idx;
    logic [PART_W-1:0] pp;
    logic [PART_W-1:0] ip;
    logic [PART_W-1:0] sp;
    acc = 1'b0;
    idx = '0;
    pp  = '0;
    ip  = '0;
    sp  = '0;
    next_state = state;
    acc = psel & penable;
    idx = paddr[7:2];

    // register writes take effect on the access edge
    if (acc && pwrite)
    begin
      if (paddr < PART_CTL_BASE)
      begin
        // mode change only alters this port's cfg, so unrelated partitions see nothing
        next_state.port_cfg[idx[3:0]].mode =
          port_mode_t'(pwdata[MODE_LSB +: 2]);
        next_state.port_cfg[idx[3:0]].port_partition_select =
          pwdata[PSEL_LSB +: PART_W];
      end
      else if (paddr < PART_STS_BASE)
      begin
        // per-partition control bits
        next_state.disable_linkdown_hot_reset[idx[3:0]] = pwdata[DLDHR_BIT];
      end
      else if (paddr >= SBR_CTL_BASE && paddr < LINK_STS_ADDR)
      begin
        // per-port secondary bus reset control
        next_state.secondary_bus_reset_bit[idx[3:0]] = pwdata[SBR_BIT];
      end
      // status and link words are read only
    end

    // register reads: loaded at the setup edge, word stands in the access cycle
    next_state.prdata = '0;
    if (psel && !penable && !pwrite)
    begin
      if (paddr < PART_CTL_BASE)
      begin
        // port mode and partition select
        next_state.prdata[MODE_LSB +: 2] = state.port_cfg[idx[3:0]].mode;
        next_state.prdata[PSEL_LSB +: PART_W] =
          state.port_cfg[idx[3:0]].port_partition_select;
      end
      else if (paddr < PART_STS_BASE)
      begin
        // link-down hot reset disable
        next_state.prdata[DLDHR_BIT] = state.disable_linkdown_hot_reset[idx[3:0]];
      end
      else if (paddr < SBR_CTL_BASE)
      begin
        // partition upstream status
        next_state.prdata[USP_BIT] = state.upstream_port_present[idx[3:0]];
        next_state.prdata[USN_LSB +: PORT_W] = state.upstream_port_number[idx[3:0]];
      end
      else if (paddr < LINK_STS_ADDR)
      begin
        // secondary bus reset bit
        next_state.prdata[SBR_BIT] = state.secondary_bus_reset_bit[idx[3:0]];
      end
      else if (paddr == LINK_STS_ADDR)
      begin
        // synced link levels
        next_state.prdata = {dl_down_sync, link_up_sync};
      end
      // unmapped words read zero
    end

    // partition status recomputed every cycle from port cfg
    next_state.upstream_port_present = '0;
    next_state.upstream_port_number  = '0;
    next_state.has_downstream        = '0;
    for (int p = NUM_PORTS - 1; p >= 0; p--)
    begin
      pp = attach_part[p];
      if (is_up[p])
      begin
        next_state.upstream_port_present[pp] = 1'b1;
        next_state.upstream_port_number[pp]  = PORT_W'(p);
      end
      if (is_down[p])
      begin
        // any downstream port makes the partition two-sided
        next_state.has_downstream[pp] = 1'b1;
      end
    end

    // link-down hot reset unless disabled per partition; only that partition
    next_state.hot_reset_run = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      sp = attach_part[p];
      if (is_up[p] && dl_down_sync[p] && !state.disable_linkdown_hot_reset[sp])
      begin
        // only the upstream port's own partition is reset
        next_state.hot_reset_run[sp] = 1'b1;
      end
    end

    // packet policy from ingress port's partition
    next_state.pkt_res = '0;
    if (pkt_req.valid)
    begin
      ip = attach_part[pkt_req.ingress_port];
      next_state.pkt_res.valid = 1'b1;
      if (!attached[pkt_req.ingress_port])
      begin
        // no partition behind the port, nothing to route to
        next_state.pkt_res.drop = 1'b1;
      end
      else if (state.secondary_bus_reset_bit[pkt_req.ingress_port] &&
               is_down[pkt_req.ingress_port])
      begin
        // port under secondary bus reset: its traffic is discarded
        next_state.pkt_res.drop = 1'b1;
      end
      else if (state.upstream_port_present[ip] && !state.has_downstream[ip])
      begin
        // upstream-only partition
        if (pkt_req.switch_generated)
        begin
          // rootward traffic still has a root to go to
          next_state.pkt_res.forward = 1'b1;
        end
        else if (pkt_req.is_completion)
        begin
          // no downstream requester can own a completion
          next_state.pkt_res.unsupported = 1'b1;
        end
        else if (pkt_req.is_cfg_to_upstream)
        begin
          // the upstream port's own config space stays reachable
          next_state.pkt_res.forward = 1'b1;
        end
        else
        begin
          // nothing below the upstream port to take a request
          next_state.pkt_res.unsupported = 1'b1;
        end
      end
      else if (!state.upstream_port_present[ip])
      begin
        // no upstream port: peers only
        if (pkt_req.switch_generated)
        begin
          // no root to deliver interrupts or messages to
          next_state.pkt_res.drop = 1'b1;
        end
        else if (pkt_req.targets_downstream)
        begin
          // peer-to-peer between downstream ports
          next_state.pkt_res.forward = 1'b1;
        end
        else
        begin
          // rootward or unclaimed traffic
          next_state.pkt_res.unsupported = 1'b1;
        end
      end
      else
      begin
        // ordinary switch form
        next_state.pkt_res.forward = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        state.port_cfg[p].mode                  <= port_mode_t'(MODE_RST);
        state.port_cfg[p].port_partition_select <= PSEL_RST;
      end
    end
    else
    begin
      state <= next_state;
    end
  end

  // port action outputs, per port and partition-local
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_act
    assign send_hot_reset_ts1[p] = is_down[p] & link_up_sync[p] &
                                   state.secondary_bus_reset_bit[p];
    assign flush_ingress_queue[p] = is_down[p] & state.secondary_bus_reset_bit[p];
    // aspm free when partition lacks the opposite side
    assign aspm_independent[p] =
      (is_up[p] & ~state.has_downstream[attach_part[p]]) |
      (is_down[p] & ~state.upstream_port_present[attach_part[p]]);
  end

  // bus, packet result and partition hot reset outputs
  assign prdata              = state.prdata;
  assign pready              = 1'b1;
  assign pslverr             = 1'b0;
  assign pkt_res             = state.pkt_res;
  assign partition_hot_reset = state.hot_reset_run;

endmodule : switch_partition_manager
`default_nettype wire

// ---- verification/link_partner.sv ----
// far-side link model: drives link up and data link down levels
`default_nettype none
module link_partner
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // wanted link levels from the bench
  input  wire logic [15:0] up_req,
  input  wire logic [15:0] down_req,
  // link status pins
  output logic      [15:0] link_up_pin,
  output logic      [15:0] dl_down_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, links down in reset
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      link_up_pin <= 16'h0;
      dl_down_pin <= 16'h0;
    end
    else
    begin
      link_up_pin <= up_req;
      dl_down_pin <= down_req;
    end
endmodule : link_partner
`default_nettype wire

// ---- verification/switch_partition_manager_sva.sv ----
// port checker for the switch partition manager
`default_nettype none
module switch_partition_manager_sva
  import partition_pkg::*;
(
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  // apb and packets
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire partition_pkg::pkt_req_t pkt_req,
  input wire partition_pkg::pkt_res_t pkt_res,
  // port actions
  input wire logic [NUM_PORTS-1:0]    send_hot_reset_ts1,
  input wire logic [NUM_PORTS-1:0]    flush_ingress_queue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PORTS-1:0] ssbr;
  logic [1:0] smode [NUM_PORTS];
  logic [3:0] ssel  [NUM_PORTS];
  logic [1:0] quiet;
  logic       att, up, dn, v;
  // shadow of port modes, quiet counts cycles since last write
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      quiet <= 2'h0;
      ssbr <= '0;
      for (int i = 0; i < NUM_PORTS; i++) {smode[i], ssel[i]} <= 6'h0;
    end
    else if (psel && penable && pwrite)
    begin
      quiet <= 2'h0;
      if (paddr < PART_CTL_BASE) {smode[paddr[5:2]], ssel[paddr[5:2]]} <= {pwdata[1:0], pwdata[7:4]};
      else if (paddr >= SBR_CTL_BASE && paddr < LINK_STS_ADDR) ssbr[paddr[5:2]] <= pwdata[SBR_BIT];
    end
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  // form of the ingress port's partition
  always_comb
  begin
    att = smode[pkt_req.ingress_port] inside {2'h1, 2'h2};
    up = 1'b0;
    dn = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      up |= smode[i] == 2'h2 && ssel[i] == ssel[pkt_req.ingress_port];
      dn |= smode[i] == 2'h1 && ssel[i] == ssel[pkt_req.ingress_port];
    end
    v = pkt_req.valid && quiet == 2'h3 &&
        !(ssbr[pkt_req.ingress_port] && smode[pkt_req.ingress_port] == 2'h1);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_APB_READY: assert property (psel |-> pready && !pslverr)
    else $error("apb not zero wait");
  AST_RES_PULSE: assert property (pkt_req.valid |=> pkt_res.valid)
    else $error("no packet result");
  AST_RES_NONE: assert property (!pkt_req.valid |=> !pkt_res.valid)
    else $error("spurious packet result");
  AST_ONEHOT: assert property (pkt_res.valid |->
    $onehot({pkt_res.forward, pkt_res.unsupported, pkt_res.drop}))
    else $error("result not one treatment");
  AST_UNATT: assert property (v && !att |=> pkt_res.drop)
    else $error("unattached port not dropped");
  AST_UPONLY_REQ: assert property (v && att && up && !dn && !pkt_req.switch_generated
    && !pkt_req.is_completion && !pkt_req.is_cfg_to_upstream |=> pkt_res.unsupported)
    else $error("request not ur");
  AST_UPONLY_CPL: assert property (v && att && up && !dn && !pkt_req.switch_generated
    && pkt_req.is_completion |=> pkt_res.unsupported) else $error("completion not ur");
  AST_NOUP_FWD: assert property (v && att && !up && pkt_req.targets_downstream
    && !pkt_req.switch_generated |=> pkt_res.forward) else $error("peer not forwarded");
  AST_NOUP_UR: assert property (v && att && !up && !pkt_req.targets_downstream
    && !pkt_req.switch_generated |=> pkt_res.unsupported) else $error("stray not ur");
  AST_NOUP_DROP: assert property (v && att && !up && pkt_req.switch_generated
    |=> pkt_res.drop) else $error("rootward not dropped");
  AST_TS1_FLUSH: assert property ((send_hot_reset_ts1 & ~flush_ingress_queue) == 16'h0)
    else $error("ts1 without flush");
  // main scenarios
  COV_UPONLY: cover property (v && att && up && !dn);
  COV_NOUP: cover property (v && att && !up);
  COV_TS1: cover property (|send_hot_reset_ts1);
endmodule : switch_partition_manager_sva
bind switch_partition_manager switch_partition_manager_sva switch_partition_manager_sva_inst (
  .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .pkt_req, .pkt_res, .send_hot_reset_ts1, .flush_ingress_queue);
`default_nettype wire

// ---- verification/tb_switch_partition_manager.sv ----
// self-checking bench for the switch partition manager
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_switch_partition_manager;
  timeunit 1ns;
  timeprecision 1ps;
  import partition_pkg::*;
  logic        core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, er;
  logic [15:0] up_req = 16'h0, down_req = 16'h0, link_up_pin, dl_down_pin;
  logic [15:0] send_hot_reset_ts1, flush_ingress_queue, aspm_independent, partition_hot_reset;
  logic [3:0]  f;
  pkt_req_t    pkt_req = '0;
  pkt_res_t    pkt_res, ep;
  logic [31:0] rdq[$];
  pkt_res_t    pq[$];
  int          miscompares = 0, num_checks = 0, cycles = 0;
  localparam logic [3:0] FWD = 4'hc, UR = 4'ha, DRP = 4'h9;
  switch_partition_manager switch_partition_manager_inst (.core_clk, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up_pin, .dl_down_pin,
    .pkt_req, .pkt_res, .send_hot_reset_ts1, .flush_ingress_queue, .aspm_independent,
    .partition_hot_reset);
  link_partner link_partner_inst (.core_clk, .reset_n, .up_req, .down_req, .link_up_pin,
    .dl_down_pin);
  // clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      complete_run();
    end
  end
  // result watcher: oldest note against each answer
  always @(posedge core_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0)
    begin
      er = rdq.pop_front();
      `CHK("prdata", er, prdata)
    end
    if (pkt_res.valid === 1'b1 && pq.size() > 0)
    begin
      ep = pq.pop_front();
      `CHK("pkt_res", ep, pkt_res)
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cfg(input logic [3:0] p, input logic [1:0] m, input logic [3:0] s);
    apb(1'b1, PORT_CTL_BASE + {6'h0, p, 2'h0}, {24'h0, s, 2'h0, m});
  endtask : cfg
  task automatic pk(input logic [3:0] p, input logic [3:0] fl, input logic [3:0] e);
    pkt_req <= {1'b1, p, fl};
    pq.push_back(pkt_res_t'(e));
    @(posedge core_clk);
  endtask : pk
  task automatic idle(input int n);
    pkt_req <= '0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic complete_run();
    if (rdq.size() + pq.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // main sequence
  initial
  begin
    void'($urandom(61));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(PORT_CTL_BASE, 32'h0);
    cfg(1, MODE_UPSTREAM, 2); cfg(3, MODE_DOWNSTREAM, 5); cfg(4, MODE_DOWNSTREAM, 5);
    cfg(15, MODE_UPSTREAM, 15); idle(4);
    rd(PART_STS_BASE + 12'h8, 32'h11); rd(PART_STS_BASE + 12'h14, 32'h0);
    rd(PART_STS_BASE + 12'h3c, 32'hf1);
    `CHK("aspm", 16'h801a, aspm_independent)
    $display("config test done");
    pk(1, 4'h0, UR); pk(1, 4'h4, FWD); pk(1, 4'h8, UR);
    pk(3, 4'h2, FWD); pk(3, 4'h0, UR); pk(4, 4'h1, DRP); idle(1);
    repeat (20)
    begin
      f = 4'($urandom);
      pk(4, f, f[0] ? DRP : (f[1] ? FWD : UR));
    end
    idle(2);
    $display("packet test done");
    up_req <= 16'h0018;
    apb(1'b1, SBR_CTL_BASE + 12'hc, 32'h40); idle(8);
    `CHK("ts1", 16'h0008, send_hot_reset_ts1)
    `CHK("flush", 16'h0008, flush_ingress_queue)
    $display("secondary reset test done");
    down_req <= 16'h8000; idle(8);
    `CHK("hot_reset", 16'h8000, partition_hot_reset)
    apb(1'b1, PART_CTL_BASE + 12'h3c, 32'h1); idle(4);
    `CHK("hot_reset", 16'h0000, partition_hot_reset)
    $display("link down test done");
    cfg(7, MODE_UNATTACHED, 2); cfg(15, MODE_DISABLED, 15); idle(4);
    rd(PART_STS_BASE + 12'h8, 32'h11); pk(7, 4'h2, DRP); idle(2);
    apb(1'b1, 12'h200, 32'hffffffff); rd(12'h200, 32'h0);
    apb(1'b1, PART_STS_BASE + 12'h8, 32'h0); rd(PART_STS_BASE + 12'h8, 32'h11);
    $display("mode change test done");
    idle(2);
    complete_run();
  end
endmodule : tb_switch_partition_manager
`default_nettype wire
